// >>> rtl/vme_pkg.sv
// Shared constants and types for the system bus interface
package vme_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int CYC_TMO_US = 64;
	localparam int CYC_TMO = CYC_TMO_US * (CLK_HZ / 1_000_000);
	localparam int TENURE_US = 64;
	localparam int TENURE = TENURE_US * (CLK_HZ / 1_000_000);
	localparam int CYC_GUARD = 16;
	localparam int BLK_TMO_S = 2;
	localparam int BLK_TMO = BLK_TMO_S * CLK_HZ;
	localparam int CNT_W = 11;
	localparam logic [CNT_W-1:0] CYC_LAST = CNT_W'(CYC_TMO - 1);
	localparam logic [CNT_W-1:0] TEN_LAST = CNT_W'(TENURE - CYC_GUARD);
	localparam logic [5:0] AM_SUP_IO = 6'h2D;
	localparam int CC_LSB = 9;
	localparam int BR_LEVELS = 4;
	localparam int IRQ_LEVELS = 7;

	typedef struct packed {
		logic sysrst_n;
		logic [23:1] a;
		logic [5:0] am;
		logic [15:0] d;
		logic write_n;
		logic as_n;
		logic ds0_n;
		logic ds1_n;
		logic dtack_n;
		logic [BR_LEVELS-1:0] bg_n;
		logic iack_n;
		logic iackin_n;
	} pins_t;

	typedef enum logic [2:0] {R_IDLE, R_REQ, R_WAIT_AS, R_OWN, R_DROP} arb_st_t;
	typedef enum logic [1:0] {S_IDLE, S_LOCAL, S_ACK} slv_st_t;
	typedef enum logic [2:0] {M_IDLE, M_BUS, M_ADDR, M_STRB, M_WAIT, M_REL, M_GAP} mst_st_t;
endpackage

// >>> rtl/arb_if.sv
// Handshake between the DMA master logic and the bus requester
`timescale 1ns/1ps
interface arb_if;
	logic want;
	logic granted;
	logic as_n;
	logic [vme_pkg::BR_LEVELS-1:0] bg_n;
	logic [1:0] level;
	modport master (output want, as_n, bg_n, level, input granted);
	modport requester (input want, as_n, bg_n, level, output granted);
endinterface

// >>> rtl/vme_requester.sv
// Release-when-done bus requester with grant daisy-chain
`timescale 1ns/1ps
module vme_requester (
	input logic clock,
	input logic srst,
	arb_if.requester arb,
	output logic [vme_pkg::BR_LEVELS-1:0] br_oe_n,
	output logic bbsy_oe_n,
	output logic [vme_pkg::BR_LEVELS-1:0] bg_out_n
);
	typedef struct packed {
		vme_pkg::arb_st_t st;
		logic [vme_pkg::BR_LEVELS-1:0] br_oe_n;
		logic bbsy_oe_n;
		logic [vme_pkg::BR_LEVELS-1:0] bg_out_n;
		logic granted;
	} req_state_t;

	req_state_t q;
	req_state_t next_q;
	logic own_bg;

	assign own_bg = ~arb.bg_n[arb.level];

	// =====================================
	// Arbitration sequence
	always_comb
	begin
		next_q = q;
		for (int i = 0; i < vme_pkg::BR_LEVELS; i++)
		begin
			if (arb.bg_n[i])
				next_q.bg_out_n[i] = 1'h1;
			else if (i != int'(arb.level) || q.st == vme_pkg::R_IDLE)
				next_q.bg_out_n[i] = 1'h0;
		end
		case (q.st)
			vme_pkg::R_IDLE:
			begin
				if (arb.want && !own_bg && q.bg_out_n[arb.level])
				begin
					next_q.br_oe_n[arb.level] = 1'h0;
					next_q.st = vme_pkg::R_REQ;
				end
			end
			vme_pkg::R_REQ:
			begin
				if (own_bg)
					next_q.st = vme_pkg::R_WAIT_AS;
			end
			vme_pkg::R_WAIT_AS:
			begin
				if (arb.as_n)
				begin
					next_q.bbsy_oe_n = 1'h0;
					next_q.br_oe_n = '1;
					next_q.granted = 1'h1;
					next_q.st = vme_pkg::R_OWN;
				end
			end
			vme_pkg::R_OWN:
			begin
				if (!arb.want)
				begin
					next_q.granted = 1'h0;
					next_q.st = vme_pkg::R_DROP;
				end
			end
			vme_pkg::R_DROP:
			begin
				if (!own_bg)
				begin
					next_q.bbsy_oe_n = 1'h1;
					next_q.st = vme_pkg::R_IDLE;
				end
			end
			default:
				next_q.st = vme_pkg::R_IDLE;
		endcase
		if (srst)
		begin
			next_q = '0;
			next_q.br_oe_n = '1;
			next_q.bbsy_oe_n = 1'h1;
			next_q.bg_out_n = '1;
		end
	end

	always_ff @(posedge clock)
		q <= next_q;

	assign arb.granted = q.granted;
	assign br_oe_n = q.br_oe_n;
	assign bbsy_oe_n = q.bbsy_oe_n;
	assign bg_out_n = q.bg_out_n;

	// =====================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	sequence grant_seen;
		q.st == vme_pkg::R_WAIT_AS ##0 arb.as_n;
	endsequence

	br_single_line_a: assert property ($countones(~br_oe_n) <= 1)
		else $error("more than one request line driven");
	busy_while_master_a: assert property (q.granted |-> !bbsy_oe_n)
		else $error("busy released while master");
	take_bus_a: assert property (grant_seen |=> !bbsy_oe_n && (&br_oe_n) && q.granted)
		else $error("bus not taken after grant and strobe high");
	grant_pass_a: assert property (q.st == vme_pkg::R_IDLE && !arb.bg_n[arb.level] |=> !bg_out_n[$past(arb.level)])
		else $error("unused grant not passed on");
endmodule

// >>> rtl/vme_system_interface.sv
// System bus interface: command channel slave, interrupter, DMA master
`timescale 1ns/1ps
// =====================================
// Contract
// - Slave decodes A1-A15 and modifiers
// - Acknowledge cycle decodes level on A1-A3
// - Slave and status byte use D0-D7
// - DMA moves 16-bit words on D0-D15
// - Write line high read, low write
// - Address strobe low marks valid address
// - Strobe rising ends previous master's cycle
// - Strobe zero low byte, one high byte
// - Slave acknowledges; master waits for acknowledge
// - Request on one configured level only
// - Grant taken if requesting, else passed on
// - Busy held low while bus master
// - One configured interrupt request line pulled low
// - Status byte only if pending on level
// - Otherwise pass acknowledge down the chain
// - Failure pulls fail line, stops commands
// - System reset input resets everything
// - Full 24-bit address, any modifier code
// - Load engine first, then request bus
// - Cycles start only after mastership obtained
// - Bounded tenures, bus released between them
// - Missing acknowledge aborts cycle, releases bus
// - Block time-out aborts and reports error
// - Slave answers only supervisory I/O modifier
// - Grant plus strobe high: busy, drop request
module vme_system_interface #(
	parameter int BLK_TMO = vme_pkg::BLK_TMO
) (
	input logic clock,
	input logic srst,
	input logic sysreset_n,
	input logic [23:1] a_in,
	output logic [23:1] a_out,
	output logic a_oe_n,
	input logic [5:0] am_in,
	output logic [5:0] am_out,
	output logic am_oe_n,
	input logic [15:0] d_in,
	output logic [15:0] d_out,
	output logic [1:0] d_oe_n,
	input logic write_n_in,
	output logic write_n_out,
	output logic write_n_oe_n,
	input logic as_n_in,
	output logic as_n_out,
	output logic as_n_oe_n,
	input logic ds0_n_in,
	output logic ds0_n_out,
	output logic ds0_n_oe_n,
	input logic ds1_n_in,
	output logic ds1_n_out,
	output logic ds1_n_oe_n,
	input logic dtack_n_in,
	output logic dtack_n_out,
	output logic dtack_n_oe_n,
	output logic [3:0] br_n_out,
	output logic [3:0] br_n_oe_n,
	input logic [3:0] bg_in_n,
	output logic [3:0] bg_out_n,
	output logic bbsy_n_out,
	output logic bbsy_n_oe_n,
	input logic iack_n,
	input logic iackin_n,
	output logic iackout_n,
	output logic [6:0] irq_n_out,
	output logic [6:0] irq_n_oe_n,
	output logic sysfail_n_out,
	output logic sysfail_n_oe_n,
	input logic [1:0] br_level,
	input logic [2:0] irq_level,
	input logic [7:0] status_id,
	input logic [15:vme_pkg::CC_LSB] cc_base,
	output logic cc_req,
	output logic cc_write,
	output logic [vme_pkg::CC_LSB-2:0] cc_addr,
	output logic [7:0] cc_wdata,
	input logic [7:0] cc_rdata,
	input logic cc_ack,
	input logic irq_set,
	output logic irq_taken,
	input logic fail_req,
	input logic dma_start,
	input logic dma_read,
	input logic [23:1] dma_addr,
	input logic [5:0] dma_am,
	input logic [15:0] dma_words,
	input logic [15:0] dma_wdata,
	output logic dma_wtake,
	output logic [15:0] dma_rdata,
	output logic dma_rvalid,
	output logic dma_busy,
	output logic dma_done,
	output logic dma_err
);
	localparam int BW = $clog2(BLK_TMO + 1);
	localparam logic [BW-1:0] BLK_LAST = BW'(BLK_TMO - 1);

	typedef struct packed {
		vme_pkg::pins_t s1;
		vme_pkg::pins_t s2;
		vme_pkg::slv_st_t sst;
		vme_pkg::mst_st_t mst;
		logic fail;
		logic ipend;
		logic iresp;
		logic iackout_n;
		logic [6:0] irq_oe_n;
		logic irq_taken;
		logic sysfail_oe_n;
		logic cc_req;
		logic cc_write;
		logic [vme_pkg::CC_LSB-2:0] cc_addr;
		logic [7:0] cc_wdata;
		logic [23:1] a_out;
		logic [5:0] am_out;
		logic addr_oe_n;
		logic [15:0] d_out;
		logic [1:0] d_oe_n;
		logic write_n;
		logic as_n;
		logic ds_n;
		logic ctl_oe_n;
		logic dtack_oe_n;
		logic want;
		logic rd;
		logic abort;
		logic dma_busy;
		logic dma_done;
		logic dma_err;
		logic dma_wtake;
		logic dma_rvalid;
		logic [15:0] words;
		logic [15:0] dma_rdata;
		logic [vme_pkg::CNT_W-1:0] cyc_cnt;
		logic [vme_pkg::CNT_W-1:0] ten_cnt;
		logic [BW-1:0] blk_cnt;
	} state_t;

	state_t q;
	state_t next_q;
	vme_pkg::pins_t p;
	logic rst;
	logic [3:0] req_br_oe_n;
	logic req_bbsy_oe_n;
	logic [3:0] req_bg_out_n;

	arb_if arb();

	assign p = q.s2;
	assign rst = srst || !q.s2.sysrst_n;
	assign arb.want = q.want;
	assign arb.as_n = p.as_n;
	assign arb.bg_n = p.bg_n;
	assign arb.level = br_level;

	vme_requester requester (
		.clock(clock),
		.srst(rst),
		.arb(arb),
		.br_oe_n(req_br_oe_n),
		.bbsy_oe_n(req_bbsy_oe_n),
		.bg_out_n(req_bg_out_n)
	);

	function automatic state_t bus_off(state_t s);
		state_t r;
		r = s;
		r.addr_oe_n = 1'h1;
		r.ctl_oe_n = 1'h1;
		r.d_oe_n = 2'h3;
		r.as_n = 1'h1;
		r.ds_n = 1'h1;
		r.want = 1'h0;
		return r;
	endfunction

	// =====================================
	// Next state
	always_comb
	begin
		logic lvl_hit;
		lvl_hit = q.ipend && p.a[3:1] == irq_level;
		next_q = q;
		next_q.s1 = {sysreset_n, a_in, am_in, d_in, write_n_in, as_n_in, ds0_n_in, ds1_n_in,
			dtack_n_in, bg_in_n, iack_n, iackin_n};
		next_q.s2 = q.s1;
		next_q.cc_req = 1'h0;
		next_q.irq_taken = 1'h0;
		next_q.dma_done = 1'h0;
		next_q.dma_err = 1'h0;
		next_q.dma_wtake = 1'h0;
		next_q.dma_rvalid = 1'h0;
		if (fail_req)
		begin
			next_q.fail = 1'h1;
			next_q.sysfail_oe_n = 1'h0;
		end

		// Command channel slave
		case (q.sst)
			vme_pkg::S_IDLE:
			begin
				if (!q.fail && q.ctl_oe_n && !p.as_n && p.iack_n && !p.ds0_n
					&& p.am == vme_pkg::AM_SUP_IO && p.a[15:vme_pkg::CC_LSB] == cc_base)
				begin
					next_q.cc_req = 1'h1;
					next_q.cc_write = !p.write_n;
					next_q.cc_addr = p.a[vme_pkg::CC_LSB-1:1];
					next_q.cc_wdata = p.d[7:0];
					next_q.sst = vme_pkg::S_LOCAL;
				end
			end
			vme_pkg::S_LOCAL:
			begin
				if (cc_ack)
				begin
					if (!q.cc_write)
					begin
						next_q.d_out[7:0] = cc_rdata;
						next_q.d_oe_n[0] = 1'h0;
					end
					next_q.dtack_oe_n = 1'h0;
					next_q.sst = vme_pkg::S_ACK;
				end
			end
			vme_pkg::S_ACK:
			begin
				if (p.ds0_n)
				begin
					next_q.dtack_oe_n = 1'h1;
					next_q.d_oe_n[0] = 1'h1;
					next_q.sst = vme_pkg::S_IDLE;
				end
			end
			default:
				next_q.sst = vme_pkg::S_IDLE;
		endcase

		// Interrupter and acknowledge chain
		if (q.iresp)
		begin
			if (p.ds0_n)
			begin
				next_q.iresp = 1'h0;
				next_q.dtack_oe_n = 1'h1;
				next_q.d_oe_n[0] = 1'h1;
			end
		end
		else if (p.iackin_n)
			next_q.iackout_n = 1'h1;
		else if (q.iackout_n && q.ctl_oe_n && !p.as_n && !p.iack_n)
		begin
			if (!lvl_hit)
				next_q.iackout_n = 1'h0;
			else if (!p.ds0_n)
			begin
				next_q.iresp = 1'h1;
				next_q.d_out[7:0] = status_id;
				next_q.d_oe_n[0] = 1'h0;
				next_q.dtack_oe_n = 1'h0;
				next_q.ipend = 1'h0;
				next_q.irq_taken = 1'h1;
			end
		end
		if (irq_set && !q.fail)
			next_q.ipend = 1'h1;
		for (int i = 0; i < vme_pkg::IRQ_LEVELS; i++)
			next_q.irq_oe_n[i] = !(next_q.ipend && irq_level == 3'(i + 1));

		// Time-out counters
		if (q.dma_busy)
		begin
			next_q.blk_cnt = q.blk_cnt + BW'(1);
			if (q.blk_cnt == BLK_LAST)
				next_q.abort = 1'h1;
		end
		if (q.mst inside {vme_pkg::M_ADDR, vme_pkg::M_STRB, vme_pkg::M_WAIT, vme_pkg::M_REL} && !(&q.ten_cnt))
			next_q.ten_cnt = q.ten_cnt + 11'h1;
		if (q.mst inside {vme_pkg::M_STRB, vme_pkg::M_WAIT})
			next_q.cyc_cnt = q.cyc_cnt + 11'h1;

		// DMA master
		case (q.mst)
			vme_pkg::M_IDLE:
			begin
				if (dma_start && !q.fail)
				begin
					next_q.a_out = dma_addr;
					next_q.am_out = dma_am;
					next_q.words = dma_words;
					next_q.rd = dma_read;
					next_q.blk_cnt = '0;
					next_q.abort = 1'h0;
					next_q.dma_busy = 1'h1;
					next_q.want = 1'h1;
					next_q.mst = vme_pkg::M_BUS;
				end
			end
			vme_pkg::M_BUS:
			begin
				next_q.ten_cnt = '0;
				if (q.abort)
				begin
					next_q = bus_off(next_q);
					next_q.dma_busy = 1'h0;
					next_q.dma_err = 1'h1;
					next_q.mst = vme_pkg::M_IDLE;
				end
				else if (arb.granted)
				begin
					next_q.addr_oe_n = 1'h0;
					next_q.ctl_oe_n = 1'h0;
					next_q.write_n = q.rd;
					next_q.mst = vme_pkg::M_ADDR;
				end
			end
			vme_pkg::M_ADDR:
			begin
				next_q.cyc_cnt = '0;
				next_q.as_n = 1'h0;
				if (!q.rd)
				begin
					next_q.d_out = dma_wdata;
					next_q.d_oe_n = 2'h0;
					next_q.dma_wtake = 1'h1;
				end
				next_q.mst = vme_pkg::M_STRB;
			end
			vme_pkg::M_STRB:
			begin
				next_q.ds_n = 1'h0;
				next_q.mst = vme_pkg::M_WAIT;
			end
			vme_pkg::M_WAIT:
			begin
				if (!p.dtack_n || q.cyc_cnt == vme_pkg::CYC_LAST || q.abort)
				begin
					if (!p.dtack_n)
					begin
						next_q.dma_rdata = p.d;
						next_q.dma_rvalid = q.rd;
						next_q.words = q.words - 16'h1;
						next_q.a_out = q.a_out + 23'h1;
					end
					else
						next_q.abort = 1'h1;
					next_q.as_n = 1'h1;
					next_q.ds_n = 1'h1;
					next_q.d_oe_n = 2'h3;
					next_q.mst = vme_pkg::M_REL;
				end
			end
			vme_pkg::M_REL:
			begin
				if (p.dtack_n)
				begin
					if (q.abort || q.words == 16'h0)
					begin
						next_q = bus_off(next_q);
						next_q.dma_busy = 1'h0;
						next_q.dma_done = !q.abort;
						next_q.dma_err = q.abort;
						next_q.mst = vme_pkg::M_IDLE;
					end
					else if (q.ten_cnt >= vme_pkg::TEN_LAST)
					begin
						next_q = bus_off(next_q);
						next_q.mst = vme_pkg::M_GAP;
					end
					else
						next_q.mst = vme_pkg::M_ADDR;
				end
			end
			vme_pkg::M_GAP:
			begin
				if (!arb.granted)
				begin
					next_q.want = 1'h1;
					next_q.mst = vme_pkg::M_BUS;
				end
			end
			default:
				next_q.mst = vme_pkg::M_IDLE;
		endcase

		if (rst)
		begin
			next_q = bus_off('0);
			next_q.s1 = '1;
			next_q.s2 = '1;
			next_q.s1.sysrst_n = sysreset_n;
			next_q.s2.sysrst_n = q.s1.sysrst_n;
			next_q.dtack_oe_n = 1'h1;
			next_q.iackout_n = 1'h1;
			next_q.irq_oe_n = '1;
			next_q.sysfail_oe_n = 1'h1;
		end
	end

	always_ff @(posedge clock)
		q <= next_q;

	// =====================================
	// Outputs
	assign a_out = q.a_out;
	assign a_oe_n = q.addr_oe_n;
	assign am_out = q.am_out;
	assign am_oe_n = q.addr_oe_n;
	assign d_out = q.d_out;
	assign d_oe_n = q.d_oe_n;
	assign write_n_out = q.write_n;
	assign write_n_oe_n = q.ctl_oe_n;
	assign as_n_out = q.as_n;
	assign as_n_oe_n = q.ctl_oe_n;
	assign ds0_n_out = q.ds_n;
	assign ds0_n_oe_n = q.ctl_oe_n;
	assign ds1_n_out = q.ds_n;
	assign ds1_n_oe_n = q.ctl_oe_n;
	assign dtack_n_out = 1'h0;
	assign dtack_n_oe_n = q.dtack_oe_n;
	assign br_n_out = 4'h0;
	assign br_n_oe_n = req_br_oe_n;
	assign bg_out_n = req_bg_out_n;
	assign bbsy_n_out = 1'h0;
	assign bbsy_n_oe_n = req_bbsy_oe_n;
	assign iackout_n = q.iackout_n;
	assign irq_n_out = 7'h00;
	assign irq_n_oe_n = q.irq_oe_n;
	assign sysfail_n_out = 1'h0;
	assign sysfail_n_oe_n = q.sysfail_oe_n;
	assign cc_req = q.cc_req;
	assign cc_write = q.cc_write;
	assign cc_addr = q.cc_addr;
	assign cc_wdata = q.cc_wdata;
	assign irq_taken = q.irq_taken;
	assign dma_wtake = q.dma_wtake;
	assign dma_rdata = q.dma_rdata;
	assign dma_rvalid = q.dma_rvalid;
	assign dma_busy = q.dma_busy;
	assign dma_done = q.dma_done;
	assign dma_err = q.dma_err;

	// =====================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence ack_missing;
		q.mst == vme_pkg::M_WAIT && q.cyc_cnt == vme_pkg::CYC_LAST && p.dtack_n;
	endsequence

	slave_modifier_a: assert property (q.cc_req |-> $past(q.s2.am) == vme_pkg::AM_SUP_IO)
		else $error("slave answered a foreign modifier");
	slave_low_byte_a: assert property (q.mst == vme_pkg::M_IDLE |-> q.d_oe_n[1])
		else $error("upper byte driven outside master cycles");
	master_granted_a: assert property (!q.ctl_oe_n |-> arb.granted)
		else $error("bus driven without mastership");
	cycle_abort_a: assert property (ack_missing |=> q.abort ##1 q.as_n && q.ds_n)
		else $error("missing acknowledge not aborted");
	tenure_bound_a: assert property (q.mst == vme_pkg::M_ADDR |-> q.ten_cnt <= vme_pkg::TEN_LAST)
		else $error("tenure exceeds its limit");
	irq_one_line_a: assert property ($countones(~q.irq_oe_n) <= 1)
		else $error("more than one interrupt line driven");
	iack_pass_a: assert property (!p.iackin_n && !p.iack_n && !p.as_n && !q.ipend && !q.iresp
		&& q.ctl_oe_n |=> !q.iackout_n)
		else $error("acknowledge not passed down the chain");
	fail_stops_a: assert property (q.fail && q.mst == vme_pkg::M_IDLE |=> q.mst == vme_pkg::M_IDLE)
		else $error("command started after failure");
endmodule

// >>> tb/vme_backplane_model.sv
// Backplane partner: bus arbiter and word memory answering the DMA master
`timescale 1ns/1ps
module vme_backplane_model (
	input logic clock,
	input logic srst,
	input logic [3:0] br_n,
	input logic bbsy_n,
	input logic ds0_n,
	input logic write_n,
	input logic [23:1] a,
	input logic [15:0] d,
	input logic [7:0] ack_delay,
	input logic ack_none,
	output logic [3:0] bg_n,
	output logic dtack_n,
	output logic [15:0] q
);
	logic [15:0] mem [0:255];
	logic [15:0] noise;
	logic [7:0] wait_cnt;
	logic drive;
	// ==========
	// Arbiter
	always_ff @(posedge clock)
	begin
		if (srst)
			bg_n <= 4'hF;
		else if (bg_n != 4'hF)
		begin
			if (!bbsy_n || br_n == 4'hF)
				bg_n <= 4'hF;
		end
		else if (bbsy_n)
		begin
			for (int i = 0; i < 4; i++)
				if (!br_n[i])
					bg_n <= ~(4'h1 << i);
		end
	end
	// ==========
	// Memory
	always_ff @(posedge clock)
	begin
		noise <= srst ? 16'h0000 : noise + 16'h3C5B;
		if (srst || ds0_n)
		begin
			wait_cnt <= 8'h00;
			dtack_n <= 1'b1;
			drive <= 1'b0;
		end
		else if (!bbsy_n && !ack_none && dtack_n)
		begin
			wait_cnt <= wait_cnt + 8'h01;
			if (wait_cnt >= ack_delay)
			begin
				dtack_n <= 1'b0;
				drive <= write_n;
				if (!write_n)
					mem[a[8:1]] <= d;
			end
		end
	end
	assign q = drive ? mem[a[8:1]] : noise;
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the system bus interface
`timescale 1ns/1ps
module testbench;
	localparam logic [23:1] BASE = 23'h7FFF80;
	localparam int BLK = 4000;
	logic clock = 1'b0, srst = 1'b1, sysreset_n = 1'b1;
	logic h_as = 1'b1, h_ds = 1'b1, h_wr = 1'b1, iack_n = 1'b1, iackin_n = 1'b1;
	logic [23:1] h_a = '0, a_out, dma_addr = BASE;
	logic [5:0] h_am = '0, am_out, dma_am = 6'h3A;
	logic [7:0] h_d = '0, cc_wdata, cc_addr, cc_rdata = 8'h00, m_delay = 8'h02, status_id = 8'h9E;
	logic [15:0] d_out, q, dma_wdata = '0, dma_rdata, dma_words = '0;
	logic [1:0] d_oe_n, br_level = 2'h2;
	logic [2:0] irq_level = 3'h5;
	logic [15:9] cc_base = 7'h35;
	logic [3:0] br_n_oe_n, bg_out_n, m_bg, bg_x = 4'hF;
	logic [6:0] irq_n_oe_n;
	logic a_oe_n, am_oe_n, write_n_out, write_n_oe_n, as_n_out, as_n_oe_n, ds0_n_out, ds0_n_oe_n;
	logic ds1_n_out, ds1_n_oe_n, dtack_n_oe_n, m_dtack, bbsy_n_oe_n, iackout_n, sysfail_n_oe_n;
	logic cc_req, cc_write, cc_ack = 1'b0, irq_set = 1'b0, fail_req = 1'b0, m_none = 1'b0;
	logic dma_start = 1'b0, dma_read = 1'b0, dma_wtake, dma_rvalid, dma_done, dma_err, dma_busy, irq_taken;
	int miscompares = 0, n_compared = 0;
	wire [23:1] a_in = a_oe_n ? h_a : a_out;
	wire [5:0] am_in = am_oe_n ? h_am : am_out;
	wire write_n_in = write_n_oe_n ? h_wr : write_n_out;
	wire as_n_in = as_n_oe_n ? h_as : as_n_out;
	wire ds0_n_in = ds0_n_oe_n ? h_ds : ds0_n_out;
	wire ds1_n_in = ds1_n_oe_n | ds1_n_out;
	wire dtack_n_in = dtack_n_oe_n & m_dtack;
	wire [3:0] bg_in_n = m_bg & bg_x;
	wire [7:0] lo = (!h_as && !h_wr) ? h_d : q[7:0];
	wire [15:0] d_in = {d_oe_n[1] ? q[15:8] : d_out[15:8], d_oe_n[0] ? lo : d_out[7:0]};
	always #20 clock = ~clock;
	vme_system_interface #(.BLK_TMO(BLK)) u_dut (
		.clock, .srst, .sysreset_n, .a_in, .a_out, .a_oe_n, .am_in, .am_out, .am_oe_n, .d_in, .d_out, .d_oe_n,
		.write_n_in, .write_n_out, .write_n_oe_n, .as_n_in, .as_n_out, .as_n_oe_n, .ds0_n_in, .ds0_n_out,
		.ds0_n_oe_n, .ds1_n_in, .ds1_n_out, .ds1_n_oe_n, .dtack_n_in, .dtack_n_out(), .dtack_n_oe_n,
		.br_n_out(), .br_n_oe_n, .bg_in_n, .bg_out_n, .bbsy_n_out(), .bbsy_n_oe_n, .iack_n, .iackin_n,
		.iackout_n, .irq_n_out(), .irq_n_oe_n, .sysfail_n_out(), .sysfail_n_oe_n, .br_level, .irq_level,
		.status_id, .cc_base, .cc_req, .cc_write, .cc_addr, .cc_wdata, .cc_rdata, .cc_ack, .irq_set,
		.irq_taken, .fail_req, .dma_start, .dma_read, .dma_addr, .dma_am, .dma_words, .dma_wdata,
		.dma_wtake, .dma_rdata, .dma_rvalid, .dma_busy, .dma_done, .dma_err
	);
	vme_backplane_model u_bus (
		.clock, .srst, .br_n(br_n_oe_n), .bbsy_n(bbsy_n_oe_n), .ds0_n(ds0_n_in), .write_n(write_n_in),
		.a(a_in), .d(d_in), .ack_delay(m_delay), .ack_none(m_none), .bg_n(m_bg), .dtack_n(m_dtack), .q
	);
	// ==========
	// Shared tasks
	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic slave(input logic wr, input logic [5:0] am, input logic [15:9] base, input logic [7:0] off,
		input logic ans);
		int i;
		@(posedge clock);
		h_a <= {8'h00, base, off};
		h_am <= am;
		h_wr <= ~wr;
		h_d <= off ^ 8'h5C;
		h_as <= 1'b0;
		h_ds <= 1'b0;
		for (i = 0; i < 8 && cc_req !== 1'b1; i++)
			@(posedge clock);
		cmp(cc_req, ans, "channel request");
		if (cc_req === 1'b1)
		begin
			cmp({cc_write, cc_addr, wr ? cc_wdata : 8'h00}, {wr, off, wr ? off ^ 8'h5C : 8'h00}, "access");
			cc_ack <= 1'b1;
			cc_rdata <= ~off;
			@(posedge clock);
			cc_ack <= 1'b0;
			for (i = 0; i < 8 && dtack_n_oe_n !== 1'b0; i++)
				@(posedge clock);
			cmp({dtack_n_oe_n, wr ? 10'h200 : {d_oe_n, d_in[7:0]}}, {1'b0, wr ? 10'h200 : {2'b10, ~off}}, "answer");
		end
		else
		begin
			ticks(6);
			cmp(dtack_n_oe_n, 1'b1, "no answer");
		end
		h_as <= 1'b1;
		h_ds <= 1'b1;
		for (i = 0; i < 8 && dtack_n_oe_n !== 1'b1; i++)
			@(posedge clock);
		ticks(1);
		cmp({dtack_n_oe_n, d_oe_n}, 3'h7, "slave release");
	endtask
	task automatic iack(input logic [2:0] lvl, input logic own);
		int i;
		@(posedge clock);
		h_a <= {20'h00000, lvl};
		h_wr <= 1'b1;
		iack_n <= 1'b0;
		iackin_n <= 1'b0;
		h_as <= 1'b0;
		h_ds <= 1'b0;
		for (i = 0; i < 8 && dtack_n_oe_n !== 1'b0 && iackout_n !== 1'b0; i++)
			@(posedge clock);
		if (own)
			cmp({dtack_n_oe_n, d_oe_n[0], d_in[7:0], iackout_n}, {2'b00, status_id, 1'b1}, "status");
		else
			cmp({dtack_n_oe_n, iackout_n}, 2'b10, "passed on");
		cmp(irq_taken, own, "status taken");
		{iack_n, iackin_n, h_as, h_ds} <= 4'hF;
		ticks(6);
		cmp({dtack_n_oe_n, iackout_n}, 2'b11, "acknowledge release");
	endtask
	task automatic dma(input logic rd, input logic [15:0] n, input logic [7:0] dly, input logic none,
		output logic err, output int ten, output int cyc, output int longest);
		int k = 0, r = 0, run = 0;
		logic prev = 1'b1, pas = 1'b1;
		ten = 0;
		longest = 0;
		@(posedge clock);
		dma_start <= 1'b1;
		dma_read <= rd;
		dma_words <= n;
		dma_wdata <= 16'hC0DE;
		m_delay <= dly;
		m_none <= none;
		@(posedge clock);
		dma_start <= 1'b0;
		for (cyc = 0; cyc < 30000 && dma_done !== 1'b1 && dma_err !== 1'b1; cyc++)
		begin
			@(posedge clock);
			if (br_n_oe_n !== 4'hF)
				cmp(br_n_oe_n, 4'(~(4'h1 << br_level)), "request level");
			if (as_n_oe_n === 1'b0)
			begin
				cmp({bbsy_n_oe_n, write_n_out, am_out}, {1'b0, rd, 6'h3A}, "cycle");
				cmp({ds1_n_out ^ ds0_n_out, dma_busy}, 2'b01, "strobes");
			end
			if (as_n_oe_n === 1'b0 && as_n_out === 1'b0 && pas === 1'b1)
				cmp(a_out, 23'(BASE + 23'(rd ? r : k)), "cycle address");
			pas = as_n_out;
			if (dma_wtake === 1'b1)
			begin
				k++;
				dma_wdata <= 16'hC0DE + 16'(k * 16'h0111);
			end
			if (dma_rvalid === 1'b1)
			begin
				cmp(dma_rdata, 16'hC0DE + 16'(r * 16'h0111), "read word");
				r++;
			end
			ten += (bbsy_n_oe_n === 1'b1 && prev === 1'b0) ? 1 : 0;
			prev = bbsy_n_oe_n;
			run = (bbsy_n_oe_n === 1'b0) ? run + 1 : 0;
			longest = (run > longest) ? run : longest;
		end
		err = dma_err;
		cmp(dma_busy, 1'b0, "busy cleared");
	endtask
	// ==========
	// Scenarios
	task automatic t_dma;
		logic e;
		int t, c, l;
		dma(1'b0, 16'h0003, 8'h02, 1'b0, e, t, c, l);
		cmp(e, 1'b0, "write block");
		dma(1'b1, 16'h0003, 8'h05, 1'b0, e, t, c, l);
		cmp(e, 1'b0, "read block");
		ticks(8);
		cmp({bbsy_n_oe_n, br_n_oe_n}, 5'h1F, "bus released");
		dma(1'b0, 16'h0002, 8'h00, 1'b1, e, t, c, l);
		cmp({e, c >= vme_pkg::CYC_TMO, c <= vme_pkg::CYC_TMO + 64}, 3'h7, "cycle time-out");
		ticks(8);
		cmp({bbsy_n_oe_n, as_n_oe_n}, 2'b11, "freed after time-out");
		dma(1'b0, 16'h0400, 8'h00, 1'b0, e, t, c, l);
		cmp({e, t > 1, l <= vme_pkg::TENURE + 16, c >= BLK - 8, c <= BLK + 64}, 5'h1F, "block time-out");
	endtask
	task automatic t_sysreset;
		@(posedge clock);
		irq_set <= 1'b1;
		@(posedge clock);
		irq_set <= 1'b0;
		sysreset_n <= 1'b0;
		ticks(6);
		cmp({irq_n_oe_n, iackout_n, bg_out_n}, 12'hFFF, "in system reset");
		sysreset_n <= 1'b1;
		ticks(6);
		cmp(irq_n_oe_n, 7'h7F, "after system reset");
	endtask
	initial
	begin
		ticks(5);
		cmp({a_oe_n, as_n_oe_n, dtack_n_oe_n, bbsy_n_oe_n, br_n_oe_n, irq_n_oe_n, sysfail_n_oe_n}, 16'hFFFF, "reset");
		srst <= 1'b0;
		ticks(4);
		slave(1'b1, 6'h2D, cc_base, 8'h00, 1'b1);
		slave(1'b0, 6'h2D, cc_base, 8'hFF, 1'b1);
		slave(1'b0, 6'h29, cc_base, 8'h01, 1'b0);
		slave(1'b1, 6'h2D, cc_base ^ 7'h01, 8'h02, 1'b0);
		$display("test slave done");
		@(posedge clock);
		irq_set <= 1'b1;
		@(posedge clock);
		irq_set <= 1'b0;
		ticks(2);
		cmp(irq_n_oe_n, 7'(~(7'h01 << (irq_level - 3'h1))), "request line");
		iack(3'h2, 1'b0);
		iack(3'h5, 1'b1);
		cmp(irq_n_oe_n, 7'h7F, "request dropped");
		iack(3'h5, 1'b0);
		$display("test interrupter done");
		for (int lv = 0; lv < 4; lv++)
		begin
			bg_x <= 4'(~(4'h1 << lv));
			ticks(5);
			cmp(bg_out_n, bg_x, "grant passed");
			bg_x <= 4'hF;
			ticks(5);
			cmp(bg_out_n, 4'hF, "grant withdrawn");
		end
		$display("test grant chain done");
		t_dma;
		$display("test dma done");
		t_sysreset;
		$display("test system reset done");
		fail_req <= 1'b1;
		@(posedge clock);
		fail_req <= 1'b0;
		ticks(3);
		cmp(sysfail_n_oe_n, 1'b0, "failure line");
		slave(1'b1, 6'h2D, cc_base, 8'h10, 1'b0);
		dma_start <= 1'b1;
		@(posedge clock);
		dma_start <= 1'b0;
		ticks(10);
		cmp(br_n_oe_n, 4'hF, "no request when failed");
		$display("test failure done");
		wrap_up;
	end
	initial
	begin
		ticks(40000);
		miscompares++;
		$display("mismatch at %0t: watchdog expired", $time);
		wrap_up;
	end
endmodule
